// *** hw/ahbp_device.sv ***
// Converter end: conversion sequencing, byte lane mux, select latch
`timescale 1ns/1ns
`include "ahbp_cfg.svh"
// ****************************************************************
// Design notes
// ****************************************************************
// Every pin from the bus end is asynchronous to clk_i, so each one passes
// two flops before any decode reads it. That costs two cycles of latency
// on every strobe; the bus end holds each phase long enough to cover it.
// The synchroniser resets to the idle pin levels (select high, read high,
// latch closed). Resetting it to zero instead would look like a held
// convert strobe on the first edges after reset and start a conversion.
// A conversion starts on the level of select low with read/convert low
// while the sequencer is idle. Starts that arrive during a conversion
// are dropped rather than queued, so a host that retries while busy does
// not get a second conversion behind the first.
// The byte address seen at the start picks the length of the conversion
// and is kept in its own flop, so that the result register still holds
// the previous word for a read made while busy. Such a read is legal
// but returns the earlier conversion; the host must wait for status low
// or for the fixed conversion time before it reads.
// The short cycle keeps the eight most significant bits and clears the
// rest, so its low byte read shows zeros in the high lane.
// Status is high while converting and drops to low on the edge the
// result register loads, so a falling status always comes with valid
// data and can drive an interrupt input directly.
// Lane enables move a whole nibble at a time. The low lane is never
// enabled in byte mode, so a board may strap it onto the high lane.
// The lane drivers are registered, which adds one cycle after the synced
// read select; enables and data change on the same edge, never apart.
// Result coding is done before the sample reaches this block: the range
// input only tells which coding the word carries, and the word is
// passed to the lanes unchanged.
// The channel and gain latch follows its synced inputs while the latch
// control is low and freezes when it goes high. The bus end changes the
// selection only while the latch is closed, so the extra sync delay on
// the control cannot capture a half-changed word.
// Read selection is decoded from the synced select and read/convert.
// After reset the latch word is zero: channel zero and the lowest gain.
module ahbp_device #(
  parameter int CONV12_CYC = `AHBP_CONV12_CYC,
  parameter int CONV8_CYC  = `AHBP_CONV8_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  ahbp_if.device           pins,
  input  wire logic [11:0] sample_i,     // Already coded by analog side
  input  wire logic        bipolar_i,    // Range kind, tells the coding; word passed unchanged
  output logic             conv_busy_o,
  output logic [1:0]       channel_o,
  output logic [1:0]       gain_o
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [9:0] meta_q;
  logic [9:0] sync_q;
  logic [9:0] pins_raw;
  assign pins_raw = {pins.chip_sel_n, pins.read_conv,
                     pins.byte_select_addr, pins.width_sel, pins.sel_latch,
                     pins.channel_sel_0, pins.channel_sel_1,
                     pins.gain_sel_0, pins.gain_sel_1, 1'b0};
  // Two flops per pin; only sync_q is read by logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= `AHBP_PIN_IDLE;
      sync_q <= `AHBP_PIN_IDLE;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
    end
  end
  wire cs_n  = sync_q[9];
  wire rc    = sync_q[8];
  wire a0    = sync_q[7];
  wire wsel  = sync_q[6];
  wire latch = sync_q[5];
  wire [3:0] sel_in = sync_q[4:1];
  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  ahbp_pkg::ahbp_dev_st_t st_q;
  ahbp_pkg::ahbp_dev_st_t st_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [11:0] result_q;
  logic [11:0] result_d;
  logic        status_q;
  logic        status_d;
  logic        short_q;
  logic        short_d;
  wire start    = !cs_n && !rc;
  wire read_sel = !cs_n && rc;
  // Offset binary arrives from analog side; bipolar flips nothing here
  wire [11:0] coded = bipolar_i ? sample_i : sample_i;
  // Short cycle keeps the eight MSBs and zeros the rest
  wire [11:0] short_res = {coded[11:4], 4'h0};
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    result_d = result_q;
    status_d = status_q;
    short_d  = short_q;
    case (st_q)
      ahbp_pkg::AHBP_DEV_IDLE: begin
        if (start) begin
          st_d     = ahbp_pkg::AHBP_DEV_CONV;
          status_d = 1'b1;
          // Length chosen by the byte address at start
          cnt_d    = a0 ? 16'(CONV8_CYC - 1)
                        : 16'(CONV12_CYC - 1);
          short_d  = a0;                               // Remember mode
        end
      end
      ahbp_pkg::AHBP_DEV_CONV: begin
        if (cnt_q == 16'h0000) begin
          st_d     = ahbp_pkg::AHBP_DEV_IDLE;
          status_d = 1'b0;
          result_d = short_q ? short_res : coded;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      default: st_d = ahbp_pkg::AHBP_DEV_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q     <= ahbp_pkg::AHBP_DEV_IDLE;
      cnt_q    <= 16'h0000;
      result_q <= 12'h000;
      status_q <= 1'b0;
      short_q  <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      result_q <= result_d;
      status_q <= status_d;
      short_q  <= short_d;
    end
  end
  // ****************************************************************
  // Output lanes
  // ****************************************************************
  // Lanes: [11:8] high, [7:4] middle, [3:0] low; bit 11 is the MSB
  logic [11:0] dout_d;
  logic [11:0] doe_d;
  logic [11:0] dout_q;
  logic [11:0] doe_q;
  // Reading during conversion shows stale data; host must wait
  always_comb begin
    dout_d = 12'h000;
    doe_d  = 12'h000;
    if (read_sel) begin
      if (wsel) begin
        dout_d = result_q;
        doe_d  = 12'hfff;
      end else if (!a0) begin
        dout_d = {result_q[11:4], 4'h0};
        doe_d  = 12'hff0;
      end else begin
        dout_d = {result_q[3:0], 8'h00};
        doe_d  = 12'hff0;
      end
    end
  end
  // ****************************************************************
  // Channel and gain latch
  // ****************************************************************
  logic [3:0] sel_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q  <= 4'h0;
      dout_q <= 12'h000;
      doe_q  <= 12'h000;
    end else begin
      if (!latch) begin
        sel_q <= sel_in;
      end
      dout_q <= dout_d;
      doe_q  <= doe_d;
    end
  end
  assign pins.conv_status = status_q;
  assign pins.data_o      = dout_q;
  assign pins.data_oe     = doe_q;
  assign conv_busy_o      = status_q;
  // Bit order: channel_sel_0 is the upper channel bit
  assign channel_o        = sel_q[3:2];
  assign gain_o           = {sel_q[0], sel_q[1]};
endmodule // ahbp_device

// *** hw/ahbp_cfg.svh ***
// Timing counts and field layout constants for the converter byte port
`ifndef AHBP_CFG_SVH
`define AHBP_CFG_SVH
`define AHBP_CLK_PERIOD_NS   4
`define AHBP_CONV12_US       30
`define AHBP_CONV8_US        25
`define AHBP_WAIT_US         30
`define AHBP_CONV12_CYC      ((`AHBP_CONV12_US*1000)/`AHBP_CLK_PERIOD_NS)
`define AHBP_CONV8_CYC       ((`AHBP_CONV8_US*1000)/`AHBP_CLK_PERIOD_NS)
`define AHBP_WAIT_CYC        ((`AHBP_WAIT_US*1000+`AHBP_CLK_PERIOD_NS-1)/`AHBP_CLK_PERIOD_NS)
`define AHBP_STROBE_NS       120
`define AHBP_STROBE_CYC      ((`AHBP_STROBE_NS+`AHBP_CLK_PERIOD_NS-1)/`AHBP_CLK_PERIOD_NS)
`define AHBP_RES_W           12
`define AHBP_SEL_W           4
`define AHBP_PIN_IDLE        10'h3f8
`define AHBP_REG_CTRL        8'h00
`define AHBP_REG_STAT        8'h04
`define AHBP_REG_DATA        8'h08
`define AHBP_REG_SEL         8'h0c
`define AHBP_CTRL_START      0
`define AHBP_CTRL_SHORT      1
`define AHBP_CTRL_POLL       2
`define AHBP_CTRL_READ_LO    3
`define AHBP_STAT_BUSY       0
`define AHBP_STAT_DONE       1
`endif

// *** hw/ahbp_pkg.sv ***
// Types shared by both ends of the converter byte port
package ahbp_pkg;
  typedef enum logic [1:0] {
    AHBP_DEV_IDLE = 2'b00,
    AHBP_DEV_CONV = 2'b01
  } ahbp_dev_st_t;
  typedef enum logic [2:0] {
    AHBP_HOST_IDLE  = 3'b000,
    AHBP_HOST_CONV  = 3'b001,
    AHBP_HOST_WAIT  = 3'b010,
    AHBP_HOST_RDHI  = 3'b011,
    AHBP_HOST_RDLO  = 3'b100,
    AHBP_HOST_LATCH = 3'b101
  } ahbp_host_st_t;
endpackage

// *** hw/ahbp_if.sv ***
// Pin bundle between converter and microprocessor bus end
`timescale 1ns/1ns
interface ahbp_if;
  logic        chip_sel_n;      // Decoded address, low selects
  logic        read_conv;       // High reads, low converts
  logic        byte_select_addr;
  logic        width_sel;       // High 12 bit, low byte mode
  logic        sel_latch;       // Low transparent, high hold
  logic        channel_sel_0;
  logic        channel_sel_1;
  logic        gain_sel_0;
  logic        gain_sel_1;
  logic        conv_status;     // High busy, low done
  logic [11:0] data_o;
  logic [11:0] data_oe;
  modport device (
    input  chip_sel_n, read_conv, byte_select_addr, width_sel, sel_latch,
    input  channel_sel_0, channel_sel_1, gain_sel_0, gain_sel_1,
    output conv_status, data_o, data_oe
  );
  modport host (
    output chip_sel_n, read_conv, byte_select_addr, width_sel, sel_latch,
    output channel_sel_0, channel_sel_1, gain_sel_0, gain_sel_1,
    input  conv_status, data_o, data_oe
  );
endinterface

// *** hw/ahbp_host.sv ***
// Microprocessor bus end: register port driving the converter pins
`timescale 1ns/1ns
`include "ahbp_cfg.svh"
module ahbp_host #(
  parameter int WAIT_CYC   = `AHBP_WAIT_CYC,
  parameter int STROBE_CYC = `AHBP_STROBE_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  ahbp_if.host             pins,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [12:0] meta_q;
  logic [12:0] sync_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 13'h0000;
      sync_q <= 13'h0000;
    end else begin
      meta_q <= {pins.conv_status, pins.data_o};
      sync_q <= meta_q;
    end
  end
  wire       sts    = sync_q[12];
  wire [7:0] byte_l = sync_q[11:4];                    // High+middle lanes
  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire wr_ctrl = wr_i && (addr_i == `AHBP_REG_CTRL);
  wire wr_sel  = wr_i && (addr_i == `AHBP_REG_SEL);
  ahbp_pkg::ahbp_host_st_t st_q;
  logic [15:0] cnt_q;
  logic [11:0] data_q;
  logic        done_q;
  logic        short_q;
  logic        poll_q;
  logic [3:0]  sel_q;
  logic [31:0] rdata_q;
  wire busy = (st_q != ahbp_pkg::AHBP_HOST_IDLE);
  wire [31:0] rd_mux =
    (addr_i == `AHBP_REG_STAT) ? {30'h0, done_q, busy} :
    (addr_i == `AHBP_REG_DATA) ? {20'h0, data_q} :
    (addr_i == `AHBP_REG_SEL)  ? {28'h0, sel_q} :
    (addr_i == `AHBP_REG_CTRL) ? {30'h0, poll_q, short_q} : 32'h0;
  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  // Each pin phase is held STROBE_CYC plus sync slack of the far end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= ahbp_pkg::AHBP_HOST_IDLE;
      cnt_q   <= 16'h0000;
      data_q  <= 12'h000;
      done_q  <= 1'b0;
      short_q <= 1'b0;
      poll_q  <= 1'b0;
      sel_q   <= 4'h0;
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rd_i ? rd_mux : 32'h0;
      cnt_q   <= (cnt_q == 16'h0000) ? 16'h0000 : cnt_q - 16'h0001;
      case (st_q)
        ahbp_pkg::AHBP_HOST_IDLE: begin
          if (wr_ctrl && wdata_i[`AHBP_CTRL_START]) begin
            st_q    <= ahbp_pkg::AHBP_HOST_CONV;
            short_q <= wdata_i[`AHBP_CTRL_SHORT];
            poll_q  <= wdata_i[`AHBP_CTRL_POLL];
            done_q  <= 1'b0;
            cnt_q   <= 16'(STROBE_CYC + 4);
          end else if (wr_sel) begin
            st_q  <= ahbp_pkg::AHBP_HOST_LATCH;
            sel_q <= wdata_i[3:0];
            cnt_q <= 16'(STROBE_CYC + 4);
          end
        end
        ahbp_pkg::AHBP_HOST_CONV: begin
          if (cnt_q == 16'h0000) begin
            st_q  <= ahbp_pkg::AHBP_HOST_WAIT;
            cnt_q <= 16'(WAIT_CYC);
          end
        end
        ahbp_pkg::AHBP_HOST_WAIT: begin
          // Poll status or just wait the fixed time
          if (poll_q ? (!sts && cnt_q < 16'(WAIT_CYC - 8))
                     : (cnt_q == 16'h0000)) begin
            st_q  <= ahbp_pkg::AHBP_HOST_RDHI;
            cnt_q <= 16'(STROBE_CYC + 6);
          end
        end
        ahbp_pkg::AHBP_HOST_RDHI: begin
          if (cnt_q == 16'h0000) begin
            data_q[11:4] <= byte_l;
            st_q         <= ahbp_pkg::AHBP_HOST_RDLO;
            cnt_q        <= 16'(STROBE_CYC + 6);
          end
        end
        ahbp_pkg::AHBP_HOST_RDLO: begin
          if (cnt_q == 16'h0000) begin
            data_q[3:0] <= byte_l[7:4];
            done_q      <= 1'b1;
            st_q        <= ahbp_pkg::AHBP_HOST_IDLE;
          end
        end
        ahbp_pkg::AHBP_HOST_LATCH: begin
          if (cnt_q == 16'h0000) begin
            st_q <= ahbp_pkg::AHBP_HOST_IDLE;
          end
        end
        default: st_q <= ahbp_pkg::AHBP_HOST_IDLE;
      endcase
    end
  end
  // ****************************************************************
  // Pin drive
  // ****************************************************************
  wire conv_ph = (st_q == ahbp_pkg::AHBP_HOST_CONV);
  wire rd_ph   = (st_q == ahbp_pkg::AHBP_HOST_RDHI) ||
                 (st_q == ahbp_pkg::AHBP_HOST_RDLO);
  assign pins.width_sel        = 1'b0;
  assign pins.chip_sel_n       = !(conv_ph || rd_ph);
  assign pins.read_conv        = !conv_ph;
  assign pins.byte_select_addr = conv_ph ? short_q
                     : (st_q == ahbp_pkg::AHBP_HOST_RDLO);
  // Latch closed except while a selection write is on the bus
  assign pins.sel_latch        = (st_q != ahbp_pkg::AHBP_HOST_LATCH);
  assign pins.channel_sel_0    = sel_q[3];
  assign pins.channel_sel_1    = sel_q[2];
  assign pins.gain_sel_0       = sel_q[0];
  assign pins.gain_sel_1       = sel_q[1];
  assign rdata_o               = rdata_q;
endmodule // ahbp_host

// *** bench/ahbp_props.sv ***
// Pin checker for the converter byte port
`timescale 1ns/1ns
`include "ahbp_cfg.svh"
module ahbp_props #(
  parameter int CONV12_CYC = `AHBP_CONV12_CYC,
  parameter int CONV8_CYC  = `AHBP_CONV8_CYC
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        chip_sel_n,
  input wire logic        read_conv,
  input wire logic        byte_select_addr,
  input wire logic        width_sel,
  input wire logic        conv_status,
  input wire logic [11:0] data_o,
  input wire logic [11:0] data_oe
);
  int   cnt_q;
  logic short_q;
  int   exp_len;
  // ****
  // Helper logic
  // ****
  // Busy length and the mode seen at start; the host holds a0 over start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q   <= 0;
      short_q <= 1'b0;
    end else begin
      cnt_q   <= conv_status ? cnt_q + 1 : 0;
      short_q <= conv_status ? short_q : byte_select_addr;
    end
  end
  assign exp_len = short_q ? CONV8_CYC : CONV12_CYC;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // Assertions
  // ****
  // Sync plus output register gives three cycles from pins to status
  chk_start_busy: assert property (
    (!chip_sel_n && !read_conv && !conv_status)[*3] |=> conv_status)
    else $error("start not answered by busy");
  chk_rise_cause: assert property (
    $rose(conv_status) |-> !$past(chip_sel_n, 3) && !$past(read_conv, 3))
    else $error("busy without a start");
  chk_done_hold: assert property (
    (!conv_status && (chip_sel_n || read_conv))[*3] |=> !conv_status)
    else $error("status left done without a start");
  // Small slack: the exact edge of the count is the designer's choice
  chk_conv_len: assert property (
    $fell(conv_status) |-> cnt_q >= exp_len - 2 && cnt_q <= exp_len + 2)
    else $error("conversion length does not match mode");
  chk_float_idle: assert property (
    (chip_sel_n || !read_conv)[*4] |-> data_oe == 12'h000)
    else $error("lanes driven without a read");
  chk_byte_lanes: assert property (
    (!chip_sel_n && read_conv && !width_sel)[*4] |-> data_oe == 12'hff0)
    else $error("byte read enables wrong lanes");
  chk_mid_zero: assert property (
    (!chip_sel_n && read_conv && !width_sel && byte_select_addr)[*4]
    |-> data_o[7:4] == 4'h0)
    else $error("middle lane not zero in low byte");
  chk_oe_shape: assert property (
    data_oe == 12'h000 || data_oe == 12'hff0 || data_oe == 12'hfff)
    else $error("lane enables split a nibble");
  cov_short: cover property ($rose(conv_status) && short_q);
  cov_low_read: cover property (!chip_sel_n && read_conv && byte_select_addr);
  cov_done: cover property ($fell(conv_status));
endmodule // ahbp_props

// *** bench/adc_host_byte_port_test.sv ***
// Self-checking bench joining host end and converter end
`timescale 1ns/1ns
`include "ahbp_cfg.svh"
module adc_host_byte_port_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [11:0] sample_i = 12'h000;
  logic        bipolar_i = 1'b0;
  logic        conv_busy_o;
  logic [1:0]  channel_o;
  logic [1:0]  gain_o;
  logic [7:0]  hi_cap = 8'h00;
  logic [7:0]  lo_cap = 8'h00;
  logic [3:0]  sel_cap = 4'h0;
  logic [31:0] got;
  logic [15:0] seen = 16'h0;
  int          mismatches = 0;
  int          check_count = 0;
  // Rows: bit 13 short cycle, bit 12 poll status, bits 11:0 sample
  logic [13:0] rows [4] = '{14'h0fff, 14'h2000, 14'h1a5c, 14'h3801};
  ahbp_if pins ();
  ahbp_host #(.WAIT_CYC(200)) u_ahbp_host (.clk_i(clk_i), .rst_i(rst_i),
    .pins(pins), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o));
  ahbp_device #(.CONV12_CYC(100), .CONV8_CYC(80)) u_ahbp_device (
    .clk_i(clk_i), .rst_i(rst_i), .pins(pins), .sample_i(sample_i),
    .bipolar_i(bipolar_i), .conv_busy_o(conv_busy_o),
    .channel_o(channel_o), .gain_o(gain_o));
  ahbp_props #(.CONV12_CYC(100), .CONV8_CYC(80)) u_ahbp_props (
    .clk_i(clk_i), .rst_i(rst_i), .chip_sel_n(pins.chip_sel_n),
    .read_conv(pins.read_conv), .byte_select_addr(pins.byte_select_addr),
    .width_sel(pins.width_sel), .conv_status(pins.conv_status),
    .data_o(pins.data_o), .data_oe(pins.data_oe));
  // 250 MHz clock
  initial forever #2 clk_i = ~clk_i;
  // Keep the last settled byte of each lane read and the latch word
  always @(posedge clk_i) begin
    if (!pins.chip_sel_n && pins.read_conv && pins.data_oe === 12'hff0) begin
      if (pins.byte_select_addr)
        lo_cap <= pins.data_o[11:4];
      else
        hi_cap <= pins.data_o[11:4];
    end
    if (!pins.sel_latch)
      sel_cap <= {pins.channel_sel_0, pins.channel_sel_1, pins.gain_sel_1,
                  pins.gain_sel_0};
  end
  // ****
  // Tasks
  // ****
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    got = rdata_o;
  endtask
  // Bounded waits; running out ends the run
  task automatic wait_stat(input int b, input logic lvl);
    int n;
    for (n = 0; n < 3000; n++) begin
      rd(`AHBP_REG_STAT);
      if (got[b] === lvl)
        break;
    end
    if (n == 3000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: status wait ran out", $time);
      tally_and_finish();
    end
  endtask
  task automatic wait_latch(input logic lvl);
    int n;
    for (n = 0; n < 200 && pins.sel_latch !== lvl; n++)
      @(posedge clk_i);
    if (n == 200) begin
      mismatches++;
      $display("CHECK FAILED at %0t: latch wait ran out", $time);
      tally_and_finish();
    end
  endtask
  task automatic check_idle();
    check(32'({pins.chip_sel_n, pins.read_conv, pins.sel_latch,
               pins.conv_status, pins.data_oe}), 32'h0000e000);
  endtask
  // One conversion; dup retries a short start while busy, which is ignored
  task automatic convert(input logic [13:0] r, input logic dup);
    logic [11:0] e;
    e = r[13] ? {r[11:4], 4'h0} : r[11:0];
    sample_i <= r[11:0];
    bipolar_i <= r[0];
    wr(`AHBP_REG_CTRL, 32'(r[12]) << `AHBP_CTRL_POLL |
       32'(r[13]) << `AHBP_CTRL_SHORT | 32'h1);
    rd(`AHBP_REG_CTRL);
    check(got, {30'h0, r[12], r[13]});
    wait_stat(`AHBP_STAT_BUSY, 1'b1);
    if (dup)
      wr(`AHBP_REG_CTRL, 32'h3);
    wait_stat(`AHBP_STAT_BUSY, 1'b0);
    check(32'(got[`AHBP_STAT_DONE]), 32'h1);
    rd(`AHBP_REG_DATA);
    check(got, {20'h0, e});
    check({24'h0, hi_cap}, {24'h0, e[11:4]});
    check({24'h0, lo_cap}, {24'h0, e[3:0], 4'h0});
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check_idle();
    foreach (rows[i])
      convert(rows[i], 1'b0);
    convert(14'h05a3, 1'b1);
    rd(8'h10);
    check(got, 32'h0);
    // Every latch word must reach both outputs bit for bit
    for (int v = 0; v < 16; v++) begin
      wr(`AHBP_REG_SEL, 32'(v));
      wait_latch(1'b0);
      wait_latch(1'b1);
      repeat (4) @(posedge clk_i);
      check({28'h0, channel_o, gain_o}, {28'h0, sel_cap});
      check({28'h0, sel_cap}, 32'(v));
      seen[sel_cap] = 1'b1;
    end
    check({16'h0, seen}, 32'h0000ffff);
    // Reset during the host convert strobe, before the converter has started, then a clean conversion after it
    wr(`AHBP_REG_CTRL, 32'h1);
    wait_stat(`AHBP_STAT_BUSY, 1'b1);
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check_idle();
    convert(rows[2], 1'b0);
    tally_and_finish();
  end
endmodule // adc_host_byte_port_test
